// [logic/mid_cfg.svh]
// Encodings, field positions and timing counts of the instruction decoder
`ifndef MID_CFG_SVH
`define MID_CFG_SVH

// Timing: one instruction cycle is four oscillator clocks
`define MID_CLK_PERIOD_NS   100
`define MID_OSC_PER_ICYC    4
`define MID_PHASE_LAST      2'h3

// Field positions inside the 14-bit word
`define MID_DEST_BIT        7
`define MID_STORE_BIT       7
`define MID_PTR_K_BIT       6
`define MID_PTR_M_BIT       2

// Addresses of the two indirect data ports
`define MID_IND_PORT0       7'h00
`define MID_IND_PORT1       7'h01

// Fixed control words
`define MID_W_BRANCH_ACC    14'h000B
`define MID_W_CALL_ACC      14'h000A
`define MID_W_RET_IRQ       14'h0009
`define MID_W_RETURN        14'h0008
`define MID_W_KICK_WDT      14'h0064
`define MID_W_STANDBY       14'h0063
`define MID_W_SW_RESET      14'h0001

// Pattern words, don't-care bits marked with ?
`define MID_P_ADDC          14'b11_1101_????_????
`define MID_P_SUBB          14'b11_1011_????_????
`define MID_P_ASR           14'b11_0111_????_????
`define MID_P_DECSZ         14'b00_1011_????_????
`define MID_P_INCSZ         14'b00_1111_????_????
`define MID_P_BTSC          14'b01_10??_????_????
`define MID_P_BTSS          14'b01_11??_????_????
`define MID_P_SUBLIT        14'b11_1100_????_????
`define MID_P_LOADPCH       14'b11_0001_1???_????
`define MID_P_ADDPTR        14'b11_0001_0???_????
`define MID_P_RETLIT        14'b11_0100_????_????
`define MID_P_INDMODE       14'b00_0000_0001_????
`define MID_P_INDIDX        14'b11_1111_????_????
`define MID_P_CALL          14'b10_0???_????_????
`define MID_P_JUMP          14'b10_1???_????_????
`define MID_P_BRANCH        14'b11_001?_????_????

`endif

// [logic/mid_decoder.sv]
// Instruction decoder and cycle sequencer of the accumulator core
// Notes on behaviour
// - 11 1101 d f: accumulator plus carry plus file; C, digit carry, Z; one cycle.
// - Subtract accumulator with borrow from file; C, digit carry, Z; one cycle.
// - 11 0111 d f: arithmetic shift right of file; C and Z; one cycle.
// - 00 1011: decrement file, skip next on zero; 1 or 2 cycles; no flags.
// - 00 1111: increment file, skip next on zero; 1 or 2 cycles; no flags.
// - 01 10bb: test file bit, skip next when clear.
// - 01 11bb: test file bit, skip next when set.
// - 11 1100: literal minus accumulator into accumulator; C, digit carry, Z.
// - 11 0001 1k: load 7-bit literal into the PC high latch.
// - Word 000B: branch relative by the accumulator, two cycles.
// - Word 000A: call through the accumulator, pushing return, two cycles.
// - Word 0009: return from interrupt, two cycles.
// - Word 0008: pop return stack into PC, two cycles.
// - 11 0100: literal into accumulator and return, two cycles.
// - Word 0064: kick watchdog, update timeout and powerdown flags.
// - Word 0063: enter standby, update timeout and powerdown flags.
// - Word 0001: software device reset in one cycle.
// - 11 0001 0n k: add signed 6-bit literal to pointer n.
// - 00 0000 0001 0nmm: load via pointer n with pre/post step; Z.
// - 11 1111 0n k: indexed load through pointer n; 1n k stores instead.
// - PC change or true test adds a second cycle run as no-op.
// - Indirect access with pointer MSB set costs one extra cycle.
// - Destination bit 0 routes result to accumulator, 1 to file.
// - One instruction cycle is four oscillator clocks.
`default_nettype none
`timescale 1ns/1ps
`include "mid_cfg.svh"
module mid_decoder (
	input  wire logic             CLK_IN,
	input  wire logic             RESET_IN,
	input  wire logic [13:0]      INSTR_IN,
	input  wire logic             INSTR_VALID_IN,
	input  wire logic             RESULT_ZERO_IN,
	input  wire logic             TEST_BIT_IN,
	input  wire logic [1:0]       PTR_MSB_IN,
	output logic                  FETCH_READY_OUT,
	output logic [1:0]            PHASE_OUT,
	output logic                  CYCLE_END_OUT,
	output var mid_pkg::mid_op_t  OP_OUT,
	output logic                  DEST_FILE_OUT,
	output logic [6:0]            FILE_ADDR_OUT,
	output logic [2:0]            BIT_SEL_OUT,
	output logic [10:0]           LITERAL_OUT,
	output logic                  PTR_SEL_OUT,
	output logic [1:0]            PTR_MODE_OUT,
	output logic                  FLAG_C_EN_OUT,
	output logic                  FLAG_DIGIT_CARRY_EN_OUT,
	output logic                  FLAG_Z_EN_OUT,
	output logic                  FLAG_TIMEOUT_POWERDOWN_EN_OUT,
	output logic [1:0]            BASE_CYCLES_OUT,
	output logic                  PC_CHANGE_OUT,
	output logic                  PUSH_OUT,
	output logic                  POP_OUT,
	output logic                  WDT_CLEAR_OUT,
	output logic                  STANDBY_OUT,
	output logic                  SW_RESET_OUT,
	output logic                  INDIRECT_OUT,
	output logic                  FIRST_CYCLE_OUT,
	output logic                  EXTRA_CYCLE_OUT,
	output logic                  NOP_CYCLE_OUT
);

	mid_pkg::mid_dec_t   cur;
	mid_pkg::mid_state_t state;
	mid_pkg::mid_state_t next_state;
	logic                cycle_end;
	logic                need_extra;
	logic                skip_now;

	// Decoded value of an empty slot
	function automatic mid_pkg::mid_dec_t nop_dec();
		mid_pkg::mid_dec_t d;
		d = '0;
		d.op = mid_pkg::OP_NOP;
		d.base_cycles = 2'h1;
		return d;
	endfunction

	// Skip decision of a conditional op from datapath results
	function automatic logic skip_hit(input mid_pkg::mid_op_t op, input logic zero, input logic bit_val);
		logic hit;
		hit = 1'b0;
		case (op)
			mid_pkg::OP_DEC_SKIP_ZERO: hit = zero;
			mid_pkg::OP_INC_SKIP_ZERO: hit = zero;
			mid_pkg::OP_BIT_TEST_SKIP_CLEAR: hit = !bit_val;
			mid_pkg::OP_BIT_TEST_SKIP_SET: hit = bit_val;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Full decode of one fetched word
	function automatic mid_pkg::mid_dec_t decode_word(input logic [13:0] w);
		mid_pkg::mid_dec_t d;
		logic              file_op;
		d = nop_dec();
		file_op = 1'b0;
		d.file_addr = w[6:0];
		d.dest_file = w[`MID_DEST_BIT];
		d.bit_sel = w[9:7];
		casez (w)
			`MID_W_BRANCH_ACC: begin
				d.op = mid_pkg::OP_BRANCH_BY_ACC;
				d.pc_change = 1'b1;
			end
			`MID_W_CALL_ACC: begin
				d.op = mid_pkg::OP_CALL_BY_ACC;
				d.pc_change = 1'b1;
				d.push = 1'b1;
			end
			`MID_W_RET_IRQ: begin
				d.op = mid_pkg::OP_RETURN_FROM_IRQ;
				d.pc_change = 1'b1;
				d.pop = 1'b1;
			end
			`MID_W_RETURN: begin
				d.op = mid_pkg::OP_RETURN_SUB;
				d.pc_change = 1'b1;
				d.pop = 1'b1;
			end
			`MID_W_KICK_WDT: begin
				d.op = mid_pkg::OP_KICK_WATCHDOG;
				d.wdt_clear = 1'b1;
				d.flag_timeout_powerdown = 1'b1;
			end
			`MID_W_STANDBY: begin
				d.op = mid_pkg::OP_STANDBY;
				d.standby = 1'b1;
				d.flag_timeout_powerdown = 1'b1;
			end
			`MID_W_SW_RESET: begin
				d.op = mid_pkg::OP_SW_RESET;
				d.sw_reset = 1'b1;
			end
			`MID_P_INDMODE: begin
				// Bit 3 picks store over load, mm steps the pointer
				d.op = w[3] ? mid_pkg::OP_INDIRECT_STORE_ACC : mid_pkg::OP_INDIRECT_LOAD_ACC;
				d.ptr_sel = w[`MID_PTR_M_BIT];
				d.ptr_mode = w[1:0];
				d.flag_z = !w[3];
				d.indirect = 1'b1;
			end
			`MID_P_ADDC: begin
				d.op = mid_pkg::OP_ADD_ACC_CARRY_FILE;
				{d.flag_c, d.flag_digit_carry, d.flag_z} = 3'h7;
				file_op = 1'b1;
			end
			`MID_P_SUBB: begin
				d.op = mid_pkg::OP_SUB_ACC_BORROW_FILE;
				{d.flag_c, d.flag_digit_carry, d.flag_z} = 3'h7;
				file_op = 1'b1;
			end
			`MID_P_ASR: begin
				d.op = mid_pkg::OP_ARITH_SHIFT_RIGHT_FILE;
				{d.flag_c, d.flag_z} = 2'h3;
				file_op = 1'b1;
			end
			`MID_P_DECSZ: begin
				d.op = mid_pkg::OP_DEC_SKIP_ZERO;
				file_op = 1'b1;
			end
			`MID_P_INCSZ: begin
				d.op = mid_pkg::OP_INC_SKIP_ZERO;
				file_op = 1'b1;
			end
			`MID_P_BTSC: begin
				d.op = mid_pkg::OP_BIT_TEST_SKIP_CLEAR;
				d.dest_file = 1'b0;
				file_op = 1'b1;
			end
			`MID_P_BTSS: begin
				d.op = mid_pkg::OP_BIT_TEST_SKIP_SET;
				d.dest_file = 1'b0;
				file_op = 1'b1;
			end
			`MID_P_SUBLIT: begin
				d.op = mid_pkg::OP_SUB_ACC_FROM_LITERAL;
				d.literal = {3'h0, w[7:0]};
				{d.flag_c, d.flag_digit_carry, d.flag_z} = 3'h7;
			end
			`MID_P_LOADPCH: begin
				d.op = mid_pkg::OP_LOAD_PC_HIGH_LATCH;
				d.literal = {4'h0, w[6:0]};
			end
			`MID_P_ADDPTR: begin
				d.op = mid_pkg::OP_ADD_POINTER_LITERAL;
				d.ptr_sel = w[`MID_PTR_K_BIT];
				d.literal = {{5{w[5]}}, w[5:0]};
			end
			`MID_P_RETLIT: begin
				d.op = mid_pkg::OP_RETURN_WITH_LITERAL;
				d.literal = {3'h0, w[7:0]};
				d.pc_change = 1'b1;
				d.pop = 1'b1;
			end
			`MID_P_INDIDX: begin
				// Leading bit of the low byte picks store over load
				d.op = w[`MID_STORE_BIT] ? mid_pkg::OP_INDIRECT_STORE_ACC : mid_pkg::OP_INDIRECT_LOAD_ACC;
				d.ptr_sel = w[`MID_PTR_K_BIT];
				d.literal = {{5{w[5]}}, w[5:0]};
				d.flag_z = !w[`MID_STORE_BIT];
				d.indirect = 1'b1;
			end
			`MID_P_CALL: begin
				d.op = mid_pkg::OP_CALL_ABS;
				d.literal = w[10:0];
				d.pc_change = 1'b1;
				d.push = 1'b1;
			end
			`MID_P_JUMP: begin
				d.op = mid_pkg::OP_JUMP_ABS;
				d.literal = w[10:0];
				d.pc_change = 1'b1;
			end
			`MID_P_BRANCH: begin
				d.op = mid_pkg::OP_BRANCH_REL;
				d.literal = {{2{w[8]}}, w[8:0]};
				d.pc_change = 1'b1;
			end
			default: begin
				d = nop_dec();
			end
		endcase
		// File ops aimed at an indirect data port go through a pointer
		if (file_op && (w[6:0] == `MID_IND_PORT0 || w[6:0] == `MID_IND_PORT1)) begin
			d.indirect = 1'b1;
			d.ptr_sel = w[0];
		end
		d.base_cycles = d.pc_change ? 2'h2 : 2'h1;
		return d;
	endfunction

	// Four-clock instruction cycle timing
	mid_phase_gen u_phase (
		.clk_in        (CLK_IN),
		.reset_in      (RESET_IN),
		.phase_out     (PHASE_OUT),
		.cycle_end_out (cycle_end)
	);

	assign CYCLE_END_OUT = cycle_end;

	// Extra cycle and skip decisions
	assign need_extra = cur.indirect && PTR_MSB_IN[cur.ptr_sel];
	assign skip_now = skip_hit(cur.op, RESULT_ZERO_IN, TEST_BIT_IN);

	// Next cycle kind
	always_comb begin
		next_state = state;
		case (state)
			mid_pkg::ST_EXEC: begin
				if (need_extra) begin
					next_state = mid_pkg::ST_EXTRA;
				end else if (cur.pc_change || skip_now) begin
					next_state = mid_pkg::ST_FLUSH;
				end else begin
					next_state = mid_pkg::ST_EXEC;
				end
			end
			mid_pkg::ST_EXTRA: begin
				if (cur.pc_change || skip_now) begin
					next_state = mid_pkg::ST_FLUSH;
				end else begin
					next_state = mid_pkg::ST_EXEC;
				end
			end
			mid_pkg::ST_FLUSH: begin
				next_state = mid_pkg::ST_EXEC;
			end
			default: begin
				next_state = mid_pkg::ST_EXEC;
			end
		endcase
	end

	// A new word is taken only at the edge that opens an execute cycle
	assign FETCH_READY_OUT = cycle_end && (next_state == mid_pkg::ST_EXEC);

	// Sequencer state, advances once per instruction cycle
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state <= mid_pkg::ST_EXEC;
		end else if (cycle_end) begin
			state <= next_state;
		end
	end

	// Decoded word register; flush slots decode as no-op
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			cur <= '{op: mid_pkg::OP_NOP, base_cycles: 2'h1, default: '0};
		end else if (cycle_end) begin
			if (next_state == mid_pkg::ST_EXEC) begin
				cur <= INSTR_VALID_IN ? decode_word(INSTR_IN) : nop_dec();
			end else if (next_state == mid_pkg::ST_FLUSH) begin
				cur <= nop_dec();
			end
		end
	end

	// Decoded fields straight from the register
	assign OP_OUT = cur.op;
	assign DEST_FILE_OUT = cur.dest_file;
	assign FILE_ADDR_OUT = cur.file_addr;
	assign BIT_SEL_OUT = cur.bit_sel;
	assign LITERAL_OUT = cur.literal;
	assign PTR_SEL_OUT = cur.ptr_sel;
	assign PTR_MODE_OUT = cur.ptr_mode;
	assign FLAG_C_EN_OUT = cur.flag_c;
	assign FLAG_DIGIT_CARRY_EN_OUT = cur.flag_digit_carry;
	assign FLAG_Z_EN_OUT = cur.flag_z;
	assign FLAG_TIMEOUT_POWERDOWN_EN_OUT = cur.flag_timeout_powerdown;
	assign BASE_CYCLES_OUT = cur.base_cycles;
	assign PC_CHANGE_OUT = cur.pc_change;
	assign PUSH_OUT = cur.push;
	assign POP_OUT = cur.pop;
	assign WDT_CLEAR_OUT = cur.wdt_clear;
	assign STANDBY_OUT = cur.standby;
	assign SW_RESET_OUT = cur.sw_reset;
	assign INDIRECT_OUT = cur.indirect;

	// Cycle kind flags
	assign FIRST_CYCLE_OUT = (state == mid_pkg::ST_EXEC);
	assign EXTRA_CYCLE_OUT = (state == mid_pkg::ST_EXTRA);
	assign NOP_CYCLE_OUT = (state == mid_pkg::ST_FLUSH);

	// Checks on sequencing and decode
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	logic exec_end;
	assign exec_end = cycle_end && FIRST_CYCLE_OUT && !need_extra;

	chk_icycle_len: assert property (CYCLE_END_OUT |=> !CYCLE_END_OUT [*3] ##1 CYCLE_END_OUT)
		else $error("instruction cycle is not four clocks");

	chk_flush_after_pc: assert property ((exec_end && PC_CHANGE_OUT) |=> NOP_CYCLE_OUT [*4] ##1 FIRST_CYCLE_OUT)
		else $error("pc change not followed by one no-op cycle");

	chk_dec_skip: assert property ((exec_end && OP_OUT == mid_pkg::OP_DEC_SKIP_ZERO)
		|=> (NOP_CYCLE_OUT == $past(RESULT_ZERO_IN)))
		else $error("decrement skip decision wrong");

	chk_inc_skip: assert property ((exec_end && OP_OUT == mid_pkg::OP_INC_SKIP_ZERO)
		|=> (NOP_CYCLE_OUT == $past(RESULT_ZERO_IN) && !$past(FLAG_Z_EN_OUT)))
		else $error("increment skip decision wrong");

	chk_btest_clear: assert property ((exec_end && OP_OUT == mid_pkg::OP_BIT_TEST_SKIP_CLEAR)
		|=> (NOP_CYCLE_OUT != $past(TEST_BIT_IN)))
		else $error("skip on clear bit wrong");

	chk_btest_set: assert property ((exec_end && OP_OUT == mid_pkg::OP_BIT_TEST_SKIP_SET)
		|=> (NOP_CYCLE_OUT == $past(TEST_BIT_IN)))
		else $error("skip on set bit wrong");

	chk_extra_cycle: assert property ((cycle_end && FIRST_CYCLE_OUT && need_extra)
		|=> EXTRA_CYCLE_OUT [*4] ##1 !EXTRA_CYCLE_OUT)
		else $error("indirect program memory access lacks one extra cycle");

	chk_addc_decode: assert property ((FETCH_READY_OUT && INSTR_VALID_IN && INSTR_IN[13:8] == 6'h3D)
		|=> (OP_OUT == mid_pkg::OP_ADD_ACC_CARRY_FILE && FLAG_C_EN_OUT && FLAG_DIGIT_CARRY_EN_OUT && FLAG_Z_EN_OUT
		&& DEST_FILE_OUT == $past(INSTR_IN[7]) && BASE_CYCLES_OUT == 2'h1))
		else $error("add with carry decoded wrongly");

	chk_call_push: assert property ((FETCH_READY_OUT && INSTR_VALID_IN && INSTR_IN == `MID_W_CALL_ACC)
		|=> (PUSH_OUT && PC_CHANGE_OUT && BASE_CYCLES_OUT == 2'h2))
		else $error("call through accumulator does not push");

	chk_idle_nop: assert property ((FETCH_READY_OUT && !INSTR_VALID_IN)
		|=> (OP_OUT == mid_pkg::OP_NOP && !PC_CHANGE_OUT && !PUSH_OUT && !POP_OUT))
		else $error("empty slot not a no-op");

	cov_branch_flush: cover property (exec_end && PC_CHANGE_OUT ##1 NOP_CYCLE_OUT);
	cov_skip_taken: cover property (exec_end && skip_now);
	cov_extra_cycle: cover property (cycle_end && FIRST_CYCLE_OUT && need_extra);
	cov_standby: cover property (STANDBY_OUT && FLAG_TIMEOUT_POWERDOWN_EN_OUT);

endmodule
`default_nettype wire

// [logic/mid_phase_gen.sv]
// Divider that splits the oscillator into four-clock instruction cycles
`default_nettype none
`timescale 1ns/1ps
`include "mid_cfg.svh"
module mid_phase_gen (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	output logic [1:0]      phase_out,
	output logic            cycle_end_out
);

	// Free-running phase count, wraps every instruction cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_out <= 2'h0;
		end else begin
			phase_out <= phase_out + 2'h1;
		end
	end

	// Enable pulse in the last phase of each instruction cycle
	assign cycle_end_out = (phase_out == `MID_PHASE_LAST);

endmodule
`default_nettype wire

// [logic/mid_pkg.sv]
// Types shared by the instruction decoder modules
`default_nettype none
package mid_pkg;

	// Decoded operation
	typedef enum logic [4:0] {
		OP_NOP,
		OP_ADD_ACC_CARRY_FILE,
		OP_SUB_ACC_BORROW_FILE,
		OP_ARITH_SHIFT_RIGHT_FILE,
		OP_DEC_SKIP_ZERO,
		OP_INC_SKIP_ZERO,
		OP_BIT_TEST_SKIP_CLEAR,
		OP_BIT_TEST_SKIP_SET,
		OP_SUB_ACC_FROM_LITERAL,
		OP_LOAD_PC_HIGH_LATCH,
		OP_BRANCH_BY_ACC,
		OP_CALL_BY_ACC,
		OP_RETURN_FROM_IRQ,
		OP_RETURN_SUB,
		OP_RETURN_WITH_LITERAL,
		OP_KICK_WATCHDOG,
		OP_STANDBY,
		OP_SW_RESET,
		OP_ADD_POINTER_LITERAL,
		OP_INDIRECT_LOAD_ACC,
		OP_INDIRECT_STORE_ACC,
		OP_CALL_ABS,
		OP_JUMP_ABS,
		OP_BRANCH_REL
	} mid_op_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_EXEC,
		ST_EXTRA,
		ST_FLUSH
	} mid_state_t;

	// All fields of one decoded word
	typedef struct packed {
		mid_op_t     op;
		logic        dest_file;
		logic [6:0]  file_addr;
		logic [2:0]  bit_sel;
		logic [10:0] literal;
		logic        ptr_sel;
		logic [1:0]  ptr_mode;
		logic        flag_c;
		logic        flag_digit_carry;
		logic        flag_z;
		logic        flag_timeout_powerdown;
		logic [1:0]  base_cycles;
		logic        pc_change;
		logic        push;
		logic        pop;
		logic        wdt_clear;
		logic        standby;
		logic        sw_reset;
		logic        indirect;
	} mid_dec_t;

endpackage
`default_nettype wire

// [test/mid_fetch_model.sv]
// Behavioural program memory and datapath answers that feed the decoder
`timescale 1ns/1ps
`default_nettype none
module mid_fetch_model (
	input  wire logic        clk_in,
	input  wire logic        fetch_ready_in,
	output logic [13:0]      instr_out,
	output logic             instr_valid_out,
	output logic             result_zero_out,
	output logic             test_bit_out,
	output logic [1:0]       ptr_msb_out
);
	// Entry is word then {zero, bit, msb1, msb0}
	logic [17:0] prog [$];
	logic        ready_seen;

	// Append one program entry
	task automatic push(input logic [17:0] entry);
		prog.push_back(entry);
	endtask

	// Idle lines at time zero
	initial begin
		instr_out = 14'h0000;
		instr_valid_out = 1'b0;
		result_zero_out = 1'b0;
		test_bit_out = 1'b0;
		ptr_msb_out = 2'h0;
		ready_seen = 1'b0;
	end

	// Ready read mid-cycle, where it has settled
	always @(negedge clk_in) begin
		ready_seen = fetch_ready_in;
	end

	// Word held until taken; answers follow the taken word
	always @(posedge clk_in) begin
		#1;
		if (ready_seen === 1'b1 && prog.size() > 0) begin
			{result_zero_out, test_bit_out, ptr_msb_out} = prog[0][3:0];
			void'(prog.pop_front());
		end
		if (prog.size() > 0) begin
			instr_out = prog[0][17:4];
			instr_valid_out = 1'b1;
		end else begin
			// Nothing to offer: word lines toggle so no stale value lingers
			instr_out = ~instr_out;
			instr_valid_out = 1'b0;
		end
	end
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the instruction decoder and its cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Case: word, op, flag enables, controls, datapath answer, extra, flush
	typedef struct packed {
		logic [13:0]      w;
		mid_pkg::mid_op_t op;
		logic [3:0]       fl;
		logic [5:0]       ctl;
		logic [3:0]       dp;
		logic             x;
		logic             f;
	} mid_row_t;

	logic                 CLK_IN;
	logic                 RESET_IN;
	logic [13:0]          INSTR_IN;
	logic                 INSTR_VALID_IN;
	logic                 RESULT_ZERO_IN;
	logic                 TEST_BIT_IN;
	logic [1:0]           PTR_MSB_IN;
	logic                 FETCH_READY_OUT;
	logic [1:0]           PHASE_OUT;
	logic                 CYCLE_END_OUT;
	mid_pkg::mid_op_t     OP_OUT;
	logic                 DEST_FILE_OUT;
	logic [6:0]           FILE_ADDR_OUT;
	logic [2:0]           BIT_SEL_OUT;
	logic [10:0]          LITERAL_OUT;
	logic                 PTR_SEL_OUT;
	logic [1:0]           PTR_MODE_OUT;
	logic [3:0]           fl_en;
	logic [5:0]           ctl;
	logic [1:0]           BASE_CYCLES_OUT;
	logic                 INDIRECT_OUT;
	logic                 FIRST_CYCLE_OUT;
	logic                 EXTRA_CYCLE_OUT;
	logic                 NOP_CYCLE_OUT;
	mid_row_t             rows [31];
	mid_row_t             r;
	int                   n_mismatch;
	int                   n_tests;
	int                   cycles;
	int                   n;
	int                   nops;
	int                   ext;

	// Far side: program memory and datapath
	mid_fetch_model mid_fetch_model_inst (
		.clk_in(CLK_IN), .fetch_ready_in(FETCH_READY_OUT), .instr_out(INSTR_IN),
		.instr_valid_out(INSTR_VALID_IN), .result_zero_out(RESULT_ZERO_IN),
		.test_bit_out(TEST_BIT_IN), .ptr_msb_out(PTR_MSB_IN)
	);

	// Design under test
	mid_decoder mid_decoder_inst (
		.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .INSTR_IN(INSTR_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
		.RESULT_ZERO_IN(RESULT_ZERO_IN), .TEST_BIT_IN(TEST_BIT_IN), .PTR_MSB_IN(PTR_MSB_IN),
		.FETCH_READY_OUT(FETCH_READY_OUT), .PHASE_OUT(PHASE_OUT), .CYCLE_END_OUT(CYCLE_END_OUT),
		.OP_OUT(OP_OUT), .DEST_FILE_OUT(DEST_FILE_OUT), .FILE_ADDR_OUT(FILE_ADDR_OUT),
		.BIT_SEL_OUT(BIT_SEL_OUT), .LITERAL_OUT(LITERAL_OUT), .PTR_SEL_OUT(PTR_SEL_OUT),
		.PTR_MODE_OUT(PTR_MODE_OUT), .FLAG_C_EN_OUT(fl_en[3]), .FLAG_DIGIT_CARRY_EN_OUT(fl_en[2]),
		.FLAG_Z_EN_OUT(fl_en[1]), .FLAG_TIMEOUT_POWERDOWN_EN_OUT(fl_en[0]),
		.BASE_CYCLES_OUT(BASE_CYCLES_OUT),
		.PC_CHANGE_OUT(ctl[5]), .PUSH_OUT(ctl[4]), .POP_OUT(ctl[3]), .WDT_CLEAR_OUT(ctl[2]),
		.STANDBY_OUT(ctl[1]), .SW_RESET_OUT(ctl[0]), .INDIRECT_OUT(INDIRECT_OUT),
		.FIRST_CYCLE_OUT(FIRST_CYCLE_OUT), .EXTRA_CYCLE_OUT(EXTRA_CYCLE_OUT), .NOP_CYCLE_OUT(NOP_CYCLE_OUT)
	);

	// 10 MHz clock
	always #50 CLK_IN = ~CLK_IN;

	// Hang guard
	always @(posedge CLK_IN) begin
		cycles++;
		if (cycles == 1200) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// Decoded value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Clock count compare
	task automatic chk_len(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			n_mismatch++;
			$display("Error at %0t: count %h expected %h", $time, got, exp);
		end
	endtask

	// Wait for the next taking edge, then let its updates land
	task automatic take();
		int k;
		k = 0;
		while (FETCH_READY_OUT !== 1'b1 && k < 50) begin
			@(negedge CLK_IN);
			k++;
		end
		@(posedge CLK_IN);
		#1;
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		CLK_IN = 1'b0;
		RESET_IN = 1'b1;
		n_mismatch = 0;
		n_tests = 0;
		cycles = 0;
		rows = '{
			'{14'h3D85,mid_pkg::OP_ADD_ACC_CARRY_FILE,4'hE,6'h00,4'h0,1'b0,1'b0},
			'{14'h3B05,mid_pkg::OP_SUB_ACC_BORROW_FILE,4'hE,6'h00,4'h0,1'b0,1'b0},
			'{14'h3785,mid_pkg::OP_ARITH_SHIFT_RIGHT_FILE,4'hA,6'h00,4'h0,1'b0,1'b0},
			'{14'h0B85,mid_pkg::OP_DEC_SKIP_ZERO,4'h0,6'h00,4'h0,1'b0,1'b0},
			'{14'h0B85,mid_pkg::OP_DEC_SKIP_ZERO,4'h0,6'h00,4'h8,1'b0,1'b1},
			'{14'h0F85,mid_pkg::OP_INC_SKIP_ZERO,4'h0,6'h00,4'h8,1'b0,1'b1},
			'{14'h0F85,mid_pkg::OP_INC_SKIP_ZERO,4'h0,6'h00,4'h0,1'b0,1'b0},
			'{14'h1A85,mid_pkg::OP_BIT_TEST_SKIP_CLEAR,4'h0,6'h00,4'h0,1'b0,1'b1},
			'{14'h1805,mid_pkg::OP_BIT_TEST_SKIP_CLEAR,4'h0,6'h00,4'h4,1'b0,1'b0},
			'{14'h1C05,mid_pkg::OP_BIT_TEST_SKIP_SET,4'h0,6'h00,4'h4,1'b0,1'b1},
			'{14'h1C05,mid_pkg::OP_BIT_TEST_SKIP_SET,4'h0,6'h00,4'h0,1'b0,1'b0},
			'{14'h3C12,mid_pkg::OP_SUB_ACC_FROM_LITERAL,4'hE,6'h00,4'h0,1'b0,1'b0},
			'{14'h31A5,mid_pkg::OP_LOAD_PC_HIGH_LATCH,4'h0,6'h00,4'h0,1'b0,1'b0},
			'{14'h000B,mid_pkg::OP_BRANCH_BY_ACC,4'h0,6'h20,4'h0,1'b0,1'b1},
			'{14'h000A,mid_pkg::OP_CALL_BY_ACC,4'h0,6'h30,4'h0,1'b0,1'b1},
			'{14'h0009,mid_pkg::OP_RETURN_FROM_IRQ,4'h0,6'h28,4'h0,1'b0,1'b1},
			'{14'h0008,mid_pkg::OP_RETURN_SUB,4'h0,6'h28,4'h0,1'b0,1'b1},
			'{14'h3455,mid_pkg::OP_RETURN_WITH_LITERAL,4'h0,6'h28,4'h0,1'b0,1'b1},
			'{14'h0064,mid_pkg::OP_KICK_WATCHDOG,4'h1,6'h04,4'h0,1'b0,1'b0},
			'{14'h0063,mid_pkg::OP_STANDBY,4'h1,6'h02,4'h0,1'b0,1'b0},
			'{14'h0001,mid_pkg::OP_SW_RESET,4'h0,6'h01,4'h0,1'b0,1'b0},
			'{14'h3125,mid_pkg::OP_ADD_POINTER_LITERAL,4'h0,6'h00,4'h0,1'b0,1'b0},
			'{14'h0012,mid_pkg::OP_INDIRECT_LOAD_ACC,4'h2,6'h00,4'h0,1'b0,1'b0},
			'{14'h0016,mid_pkg::OP_INDIRECT_LOAD_ACC,4'h2,6'h00,4'h2,1'b1,1'b0},
			'{14'h3F05,mid_pkg::OP_INDIRECT_LOAD_ACC,4'h2,6'h00,4'h0,1'b0,1'b0},
			'{14'h3FC5,mid_pkg::OP_INDIRECT_STORE_ACC,4'h0,6'h00,4'h2,1'b1,1'b0},
			'{14'h2123,mid_pkg::OP_CALL_ABS,4'h0,6'h30,4'h0,1'b0,1'b1},
			'{14'h2923,mid_pkg::OP_JUMP_ABS,4'h0,6'h20,4'h0,1'b0,1'b1},
			'{14'h3323,mid_pkg::OP_BRANCH_REL,4'h0,6'h20,4'h0,1'b0,1'b1},
			'{14'h0700,mid_pkg::OP_NOP,4'h0,6'h00,4'h0,1'b0,1'b0},
			'{14'h0B81,mid_pkg::OP_DEC_SKIP_ZERO,4'h0,6'h00,4'hA,1'b1,1'b1}
		};
		foreach (rows[i]) mid_fetch_model_inst.push({rows[i].w, rows[i].dp});
		repeat (3) @(posedge CLK_IN);
		#1 RESET_IN = 1'b0;
		// Table cases: decode, then cycle count, flush and extra clocks
		foreach (rows[i]) begin
			r = rows[i];
			take();
			chk({BASE_CYCLES_OUT, OP_OUT, fl_en, ctl, PHASE_OUT, FIRST_CYCLE_OUT}, {(r.ctl[5] ? 2'h2 : 2'h1), r.op, r.fl, r.ctl, 3'h1});
			if (i == 0) chk({DEST_FILE_OUT, FILE_ADDR_OUT}, {1'b1, 7'h05});
			if (i == 1) chk({DEST_FILE_OUT, FILE_ADDR_OUT}, {1'b0, 7'h05});
			if (i == 12) chk(LITERAL_OUT, 11'h025);
			if (i == 21) chk({PTR_SEL_OUT, LITERAL_OUT}, {1'b0, 11'h7E5});
			if (i == 7) chk({BIT_SEL_OUT, FILE_ADDR_OUT, DEST_FILE_OUT}, {3'h5, 7'h05, 1'b0});
			if (i == 23) chk({PTR_SEL_OUT, PTR_MODE_OUT}, 3'h6);
			chk(INDIRECT_OUT, (i >= 22 && i <= 25) || i == 30);
			n = 0;
			nops = 0;
			ext = 0;
			do begin
				@(negedge CLK_IN);
				n++;
				nops += int'(NOP_CYCLE_OUT === 1'b1);
				ext += int'(EXTRA_CYCLE_OUT === 1'b1);
				if (n == 5 && r.f && !r.x) chk({ctl[5:3], OP_OUT}, {3'h0, mid_pkg::OP_NOP});
			end while (FETCH_READY_OUT !== 1'b1 && n < 20);
			chk_len(n, 4 * (1 + int'(r.x) + int'(r.f)));
			chk_len(nops, 4 * int'(r.f));
			chk_len(ext, 4 * int'(r.x));
		end
		// Nothing offered: a no-op is loaded
		take();
		chk(OP_OUT, mid_pkg::OP_NOP);
		// Reset in the middle of a call; queued off the taking edge
		@(negedge CLK_IN);
		mid_fetch_model_inst.push({14'h000A, 4'h0});
		take();
		chk(ctl[4], 1'b1);
		RESET_IN = 1'b1;
		#10 chk({PHASE_OUT, OP_OUT, FIRST_CYCLE_OUT, CYCLE_END_OUT, FETCH_READY_OUT, ctl, BASE_CYCLES_OUT}, {2'h0, mid_pkg::OP_NOP, 3'b100, 6'h00, 2'h1});
		repeat (3) @(posedge CLK_IN);
		#1 RESET_IN = 1'b0;
		repeat (2) @(posedge CLK_IN);
		#1 chk({PHASE_OUT, FETCH_READY_OUT}, {2'h2, 1'b0});
		@(posedge CLK_IN);
		#1 chk({PHASE_OUT, FETCH_READY_OUT, CYCLE_END_OUT}, {2'h3, 2'b11});
		wrap_up();
	end
endmodule
`default_nettype wire
